// *** core/flash_writer.v ***
// writer-mode command sequencer: entry delays, auto-erase, status polling, status read
// assumes a programmer on the parallel pins; flash array reads come from array_rdata
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "flash_writer_regs.vh"
module flash_writer
#(
	parameter SETTLE_CYCLES = (`OSC_SETTLE_MS * `CLK_FREQ_KHZ),
	parameter SETUP_CYCLES  = (`SETUP_MS * `CLK_FREQ_KHZ),
	parameter ERASE_CYCLES  = (`ERASE_MIN_MS * `CLK_FREQ_KHZ),
	parameter ADDR_W        = 18
)
(
	input  wire              clk_sys,
	input  wire              sys_rst,
	input  wire              ce_n,
	input  wire              oe_n,
	input  wire              we_n,
	input  wire [ADDR_W-1:0] addr,
	input  wire [7:0]        data_in,
	input  wire [7:0]        array_rdata,
	input  wire              erase_fail,
	output reg  [7:0]        data_out,
	output reg               data_oe,
	output reg  [ADDR_W-1:0] array_addr,
	output reg               array_erase,
	output reg               ready
);
	localparam [2:0] ST_SETTLE = 3'd0;
	localparam [2:0] ST_SETUP  = 3'd1;
	localparam [2:0] ST_WAIT   = 3'd2;
	localparam [2:0] ST_READ   = 3'd3;
	localparam [2:0] ST_ERASE  = 3'd4;
	localparam [2:0] ST_POLL   = 3'd5;
	localparam [2:0] ST_STATUS = 3'd6;

	localparam [1:0] OUT_ARRAY  = 2'd0;
	localparam [1:0] OUT_POLL   = 2'd1;
	localparam [1:0] OUT_STATUS = 2'd2;

	wire ce_s;
	wire oe_s;
	wire we_s;
	wire [7:0]        din_s;
	wire [ADDR_W-1:0] addr_s;
	reg  [7:0]        din_m_q;
	reg  [7:0]        din_q;
	reg  [ADDR_W-1:0] addr_m_q;
	reg  [ADDR_W-1:0] addr_q;
	reg               erase_fail_m_q;
	reg               erase_fail_q;

	pin_sync u_ce (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(ce_n), .q(ce_s));
	pin_sync u_oe (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(oe_n), .q(oe_s));
	pin_sync u_we (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(we_n), .q(we_s));

	// buses are sampled on the same two stages; they settle long before the strobe edge
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			din_m_q        <= 8'h00;
			din_q          <= 8'h00;
			addr_m_q       <= {ADDR_W{1'b0}};
			addr_q         <= {ADDR_W{1'b0}};
			erase_fail_m_q <= 1'b0;
			erase_fail_q   <= 1'b0;
		end
		else
		begin
			din_m_q        <= data_in;
			din_q          <= din_m_q;
			addr_m_q       <= addr;
			addr_q         <= addr_m_q;
			erase_fail_m_q <= erase_fail;
			erase_fail_q   <= erase_fail_m_q;
		end
	end
	assign din_s  = din_q;
	assign addr_s = addr_q;

	// command write is taken on the rising edge of write enable with chip enabled
	reg  we_prev_q;
	wire cmd_wr = we_s && !we_prev_q && !ce_s;

	reg [2:0]  state_q;
	reg [2:0]  state_d;
	reg [1:0]  out_sel_q;
	reg [1:0]  out_sel_d;
	reg [7:0]  first_cmd_q;
	reg [7:0]  first_cmd_d;
	reg        have_first_q;
	reg        have_first_d;
	reg [7:0]  status_q;
	reg [7:0]  status_d;
	reg        poll_done_q;
	reg        poll_done_d;
	reg        poll_pass_q;
	reg        poll_pass_d;
	reg        timer_load;
	reg [31:0] timer_count;
	wire       timer_done;

	cycle_timer #(.WIDTH(32)) u_timer
	(
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.load    (timer_load),
		.count   (timer_count),
		.running (),
		.done    (timer_done)
	);

	// first load of the settle count happens one cycle after reset release
	reg boot_q;

	always @*
	begin
		state_d      = state_q;
		out_sel_d    = out_sel_q;
		first_cmd_d  = first_cmd_q;
		have_first_d = have_first_q;
		status_d     = status_q;
		poll_done_d  = poll_done_q;
		poll_pass_d  = poll_pass_q;
		timer_load   = 1'b0;
		timer_count  = 32'h00000000;
		case (state_q)
		ST_SETTLE:
		begin
			if (boot_q)
			begin
				timer_load  = 1'b1;
				timer_count = SETTLE_CYCLES - 1;
			end
			else if (timer_done)
			begin
				state_d     = ST_SETUP;
				timer_load  = 1'b1;
				timer_count = SETUP_CYCLES - 1;
			end
		end
		ST_SETUP:
		begin
			// write strobes are dropped until setup ends
			if (timer_done)
			begin
				state_d   = ST_READ;
				out_sel_d = OUT_ARRAY;
			end
		end
		ST_ERASE:
		begin
			// no command is decoded while the whole array clears
			if (timer_done)
			begin
				poll_done_d = 1'b1;
				poll_pass_d = !erase_fail_q;
				status_d[`STAT_ERASE_ERR_BIT] = erase_fail_q;
				status_d[`STAT_ABNORMAL_BIT]  = erase_fail_q;
				state_d = ST_WAIT;
			end
		end
		default:
		begin
			if (cmd_wr)
			begin
				// polling flags stay until the next erase starts; this write only takes the poll byte off the output
				out_sel_d = OUT_ARRAY;
				if (!have_first_q)
				begin
					if (din_s == `CMD_MEM_READ)
						state_d = ST_READ;
					else if (din_s == `CMD_AUTO_ERASE || din_s == `CMD_STATUS_READ)
					begin
						first_cmd_d  = din_s;
						have_first_d = 1'b1;
						state_d      = ST_WAIT;
					end
					else
					begin
						status_d[`STAT_CMD_ERR_BIT]  = 1'b1;
						status_d[`STAT_ABNORMAL_BIT] = 1'b1;
						state_d = ST_WAIT;
					end
					// any mode other than status read starts a fresh return code
					if (din_s != `CMD_STATUS_READ)
						status_d = (din_s == `CMD_MEM_READ || din_s == `CMD_AUTO_ERASE) ? `STAT_RESET
							: (`STAT_RESET | (8'h01 << `STAT_CMD_ERR_BIT) | (8'h01 << `STAT_ABNORMAL_BIT));
				end
				else
				begin
					have_first_d = 1'b0;
					if (din_s == first_cmd_q && first_cmd_q == `CMD_AUTO_ERASE)
					begin
						state_d     = ST_ERASE;
						poll_done_d = 1'b0;
						poll_pass_d = 1'b0;
						out_sel_d   = OUT_POLL;
						timer_load  = 1'b1;
						timer_count = ERASE_CYCLES - 1;
					end
					else if (din_s == first_cmd_q)
					begin
						state_d   = ST_STATUS;
						out_sel_d = OUT_STATUS;
					end
					else
					begin
						status_d[`STAT_CMD_ERR_BIT]  = 1'b1;
						status_d[`STAT_ABNORMAL_BIT] = 1'b1;
						state_d = ST_WAIT;
					end
				end
			end
		end
		endcase
	end

	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q      <= ST_SETTLE;
			out_sel_q    <= OUT_ARRAY;
			first_cmd_q  <= 8'h00;
			have_first_q <= 1'b0;
			status_q     <= `STAT_RESET;
			poll_done_q  <= 1'b0;
			poll_pass_q  <= 1'b0;
			we_prev_q    <= 1'b1;
			boot_q       <= 1'b1;
		end
		else
		begin
			state_q      <= state_d;
			out_sel_q    <= out_sel_d;
			first_cmd_q  <= first_cmd_d;
			have_first_q <= have_first_d;
			status_q     <= status_d;
			poll_done_q  <= poll_done_d;
			poll_pass_q  <= poll_pass_d;
			we_prev_q    <= we_s;
			boot_q       <= 1'b0;
		end
	end

	reg [7:0] dout_d;
	always @*
	begin
		case (out_sel_q)
		OUT_POLL:
		begin
			dout_d = 8'h00;
			dout_d[`POLL_BUSY_BIT] = poll_done_q;
			dout_d[`POLL_PASS_BIT] = poll_pass_q;
		end
		OUT_STATUS:
			dout_d = status_q;
		default:
			dout_d = (addr_s > `ARRAY_TOP_ADDR) ? `BLANK_BYTE : array_rdata;
		endcase
	end

	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			data_out    <= 8'h00;
			data_oe     <= 1'b0;
			array_addr  <= {ADDR_W{1'b0}};
			array_erase <= 1'b0;
			ready       <= 1'b0;
		end
		else
		begin
			data_out    <= dout_d;
			data_oe     <= !ce_s && !oe_s && we_s && state_q != ST_SETTLE && state_q != ST_SETUP;
			array_addr  <= addr_s;
			array_erase <= (state_q == ST_ERASE);
			ready       <= (state_q != ST_SETTLE) && (state_q != ST_SETUP) && (state_q != ST_ERASE);
		end
	end
endmodule

// *** core/flash_writer_regs.vh ***
// constants for the writer-mode flash sequencer
// included by every design file of the block; definitions only
`ifndef FLASH_WRITER_REGS_VH
`define FLASH_WRITER_REGS_VH

`define CMD_MEM_READ      8'h00
`define CMD_AUTO_PROGRAM  8'h40
`define CMD_AUTO_ERASE    8'h20
`define CMD_STATUS_READ   8'h71

`define STAT_ABNORMAL_BIT 7
`define STAT_CMD_ERR_BIT  6
`define STAT_PROG_ERR_BIT 5
`define STAT_ERASE_ERR_BIT 4
`define STAT_COUNT_BIT    1
`define STAT_BADADDR_BIT  0
`define STAT_RESET        8'h00

`define POLL_BUSY_BIT     7
`define POLL_PASS_BIT     6

`define CLK_FREQ_KHZ      125000
`define OSC_SETTLE_MS     10
`define SETUP_MS          10
`define ERASE_MIN_MS      100

`define ARRAY_TOP_ADDR    18'h0F77F
`define BLANK_BYTE        8'hFF
`define BLOCK_LOW_MASK    8'h7F
`define BLOCK_BYTES       8'h80

`endif

// *** core/pin_sync.v ***
// two-flop synchroniser for one level from the writer pins
// assumes the input is asynchronous to clk_sys
`timescale 1ns/1ps
`include "flash_writer_regs.vh"
module pin_sync
(
	input  wire clk_sys,
	input  wire sys_rst,
	input  wire d,
	output reg  q
);
	reg meta_q;

	// resets to the idle level of an active-low strobe so no false edge follows reset
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta_q <= 1'b1;
			q      <= 1'b1;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// *** core/cycle_timer.v ***
// down counter that pulses done when a loaded count runs out
// assumes load and the count come from the same clock domain
`timescale 1ns/1ps
`include "flash_writer_regs.vh"
module cycle_timer
#(
	parameter WIDTH = 32
)
(
	input  wire             clk_sys,
	input  wire             sys_rst,
	input  wire             load,
	input  wire [WIDTH-1:0] count,
	output reg              running,
	output wire             done
)
;
	reg [WIDTH-1:0] cnt_q;

	assign done = running && (cnt_q == {WIDTH{1'b0}});

	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_q   <= {WIDTH{1'b0}};
			running <= 1'b0;
		end
		else if (load)
		begin
			cnt_q   <= count;
			running <= 1'b1;
		end
		else if (running)
		begin
			if (cnt_q == {WIDTH{1'b0}})
				running <= 1'b0;
			else
				cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule

// *** verif/prom_programmer.sv ***
// programmer model driving the parallel writer pins
// assumes the device samples every pin through two flops
`timescale 1ns/1ps
module prom_programmer
(
	input  wire       clk_sys,
	output reg        ce_n,
	output reg        oe_n,
	output reg        we_n,
	output reg [17:0] addr,
	output reg [7:0]  data_in,
	input  wire [7:0] data_out
);
	initial
	begin
		ce_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
		addr = 18'h00000;
		data_in = 8'h00;
	end
	// six cycles per level: the synchronisers need two
	task hold;
		repeat (6) @(posedge clk_sys);
	endtask
	task cmd(input [7:0] v);
	begin
		ce_n <= 1'b0;
		data_in <= v;
		hold;
		we_n <= 1'b0;
		hold;
		we_n <= 1'b1;
		hold;
		ce_n <= 1'b1;
		// released bus shows the inverse so a stale byte cannot pass
		data_in <= ~v;
		hold;
	end
	endtask
	task rd(input [17:0] a, output [7:0] v);
	begin
		addr <= a;
		ce_n <= 1'b0;
		oe_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		v = data_out;
		ce_n <= 1'b1;
		oe_n <= 1'b1;
		hold;
	end
	endtask
endmodule

// *** verif/flash_writer_chk.sv ***
// port assertions for the writer sequencer
// bound to flash_writer; sees its ports only
`timescale 1ns/1ps
module flash_writer_chk
(
	input wire       clk_sys,
	input wire       sys_rst,
	input wire       ce_n,
	input wire       we_n,
	input wire [7:0] data_out,
	input wire       data_oe,
	input wire       array_erase,
	input wire       ready
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	settle_hold_a : assert property ($fell(sys_rst) |-> !ready [*8])
		else $error("ready after reset");
	busy_refuse_a : assert property (array_erase && $past(array_erase) |-> !ready)
		else $error("ready in erase");
	erase_entry_a : assert property ($rose(array_erase) |-> $past(ready))
		else $error("erase while not ready");
	erase_min_a : assert property ($rose(array_erase) |-> array_erase [*8])
		else $error("erase too short");
	erase_end_a : assert property ($fell(array_erase) |-> ##[0:4] ready)
		else $error("no ready after erase");
	poll_busy_a : assert property (array_erase && $past(array_erase, 5) && data_oe && $past(data_oe, 2) |-> data_out == 8'h00)
		else $error("busy poll not zero");
	chip_off_a : assert property (ce_n [*5] |-> !data_oe)
		else $error("drive while deselected");
	write_off_a : assert property (!we_n [*5] |-> !data_oe)
		else $error("drive during write");
endmodule
bind flash_writer flash_writer_chk chk_i
(
	.clk_sys     (clk_sys),
	.sys_rst     (sys_rst),
	.ce_n        (ce_n),
	.we_n        (we_n),
	.data_out    (data_out),
	.data_oe     (data_oe),
	.array_erase (array_erase),
	.ready       (ready)
);

// *** verif/flash_writer_erase_status_test.sv ***
// self-checking bench for the writer erase and status sequencer
// assumes shortened settle, setup and erase counts
`timescale 1ns/1ps
module flash_writer_erase_status_test;
	logic        clk_sys;
	logic        sys_rst;
	logic        erase_fail;
	int          erase_cycles;
	int          err_count;
	int          num_checks;
	wire         ce_n;
	wire         oe_n;
	wire         we_n;
	wire [17:0]  addr;
	wire [7:0]   data_in;
	wire [7:0]   data_out;
	wire [17:0]  array_addr;
	wire         data_oe;
	wire         array_erase;
	wire         ready;
	// array content is a pattern of the address
	wire [7:0]   array_rdata = array_addr[7:0] ^ 8'h5A;

	flash_writer #(.SETTLE_CYCLES(40), .SETUP_CYCLES(40), .ERASE_CYCLES(60)) DUT
	(
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.ce_n        (ce_n),
		.oe_n        (oe_n),
		.we_n        (we_n),
		.addr        (addr),
		.data_in     (data_in),
		.array_rdata (array_rdata),
		.erase_fail  (erase_fail),
		.data_out    (data_out),
		.data_oe     (data_oe),
		.array_addr  (array_addr),
		.array_erase (array_erase),
		.ready       (ready)
	);
	prom_programmer prog
	(
		.clk_sys  (clk_sys),
		.ce_n     (ce_n),
		.oe_n     (oe_n),
		.we_n     (we_n),
		.addr     (addr),
		.data_in  (data_in),
		.data_out (data_out)
	);
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
		if (array_erase)
			erase_cycles <= erase_cycles + 1;

	task close_out;
	begin
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	task chk(input string n, input [7:0] e, input [7:0] s, input [7:0] m);
	begin
		num_checks++;
		if ((s & m) !== (e & m))
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	end
	endtask
	task rd_chk(input [17:0] a, input [7:0] e, input [7:0] m);
		logic [7:0] v;
	begin
		prog.rd(a, v);
		chk("read_data", e, v, m);
	end
	endtask
	task wait_ready;
		int i;
	begin
		for (i = 0; i < 3000 && ready !== 1'b1; i++)
			@(posedge clk_sys);
		if (ready !== 1'b1)
		begin
			err_count++;
			close_out;
		end
	end
	endtask
	task status_mode;
	begin
		prog.cmd(8'h71);
		prog.cmd(8'h71);
	end
	endtask
	task do_erase(input logic f);
	begin
		erase_fail <= f;
		erase_cycles = 0;
		prog.cmd(8'h20);
		prog.cmd(8'h20);
		rd_chk(18'h00000, 8'h00, 8'hFF);
		wait_ready;
		chk("erase_len", 8'h01, {7'h00, erase_cycles >= 60}, 8'hFF);
	end
	endtask
	task t_entry;
	begin
		// a pair sent inside settle must not start anything
		prog.cmd(8'h20);
		prog.cmd(8'h20);
		wait_ready;
		chk("early_erase", 8'h00, erase_cycles[7:0], 8'hFF);
		rd_chk(18'h00010, 8'h4A, 8'hFF);
		rd_chk(18'h0F77F, 8'h25, 8'hFF);
		rd_chk(18'h0F780, 8'hFF, 8'hFF);
		rd_chk(18'h1FFFF, 8'hFF, 8'hFF);
	end
	endtask
	task t_pass;
	begin
		do_erase(1'b0);
		rd_chk(18'h00000, 8'hC0, 8'hFF);
		rd_chk(18'h00005, 8'hC0, 8'hFF);
		status_mode;
		rd_chk(18'h00000, 8'h00, 8'hF3);
	end
	endtask
	task t_fail;
	begin
		do_erase(1'b1);
		rd_chk(18'h00000, 8'h80, 8'hFF);
		status_mode;
		rd_chk(18'h00000, 8'h90, 8'hF3);
		status_mode;
		rd_chk(18'h00000, 8'h90, 8'hF3);
		prog.cmd(8'h00);
		rd_chk(18'h00020, 8'h7A, 8'hFF);
		status_mode;
		rd_chk(18'h00000, 8'h00, 8'hF3);
	end
	endtask
	task t_cmd_err;
	begin
		erase_fail <= 1'b0;
		erase_cycles = 0;
		prog.cmd(8'h40);
		status_mode;
		rd_chk(18'h00000, 8'hC0, 8'hF3);
		prog.cmd(8'h00);
		prog.cmd(8'h20);
		prog.cmd(8'h71);
		status_mode;
		rd_chk(18'h00000, 8'hC0, 8'hF3);
		chk("no_erase", 8'h00, erase_cycles[7:0], 8'hFF);
	end
	endtask
	initial
	begin
		sys_rst = 1'b1;
		erase_fail = 1'b0;
		erase_cycles = 0;
		err_count = 0;
		num_checks = 0;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_entry;
		t_pass;
		t_fail;
		t_cmd_err;
		close_out;
	end
endmodule
